//--- bpfs_pkg.sv
package bpfs_pkg;

  // Register byte addresses
  localparam logic [3:0] BPFS_BUSCTL_ADDR = 4'h0;
  localparam logic [3:0] BPFS_STROBE_ADDR = 4'h4;
  localparam logic [3:0] BPFS_SELECT_ADDR = 4'h8;
  localparam logic [3:0] BPFS_SDRAM_ADDR = 4'hC;

  // Reset values: every pin starts as general-purpose I/O
  localparam logic [15:0] BPFS_BUSCTL_RST = 16'h0000;
  localparam logic [7:0] BPFS_STROBE_RST = 8'h00;
  localparam logic [7:0] BPFS_SELECT_RST = 8'h00;
  localparam logic [1:0] BPFS_STEER_RST = 2'h0;

  // Field positions
  localparam int BPFS_START_LSB = 2;
  localparam int BPFS_INPROG_LSB = 0;
  localparam int BPFS_STEER_LSB = 6;

  // Writable masks; reserved bits read as zero
  localparam logic [15:0] BPFS_BUSCTL_MASK = 16'h000F;
  localparam logic [7:0] BPFS_STROBE_MASK = 8'h0F;
  localparam logic [7:0] BPFS_SELECT_MASK = 8'hFE;

  // AXI response codes
  localparam logic [1:0] BPFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BPFS_RESP_SLVERR = 2'h2;

  // Function selected for a pin
  typedef enum logic [1:0] {
    BPFS_FN_GPIO = 2'b00,
    BPFS_FN_BUS = 2'b01,
    BPFS_FN_DMA = 2'b10,
    BPFS_FN_SDRAM = 2'b11
  } bpfs_fn_t;

  // Whole routing state of all pins
  typedef struct packed {
    bpfs_fn_t start_fn;
    bpfs_fn_t inprog_fn;
    logic [3:0] strobe_bus;
    logic [7:1] select_fn_on;
    logic [3:2] select_sdram;
  } bpfs_route_t;

endpackage

//--- bpfs_decode.sv
`timescale 1ns/100ps
module bpfs_decode
  import bpfs_pkg::*;
(
  input wire logic [15:0] busctl_i,
  input wire logic [7:0] strobe_i,
  input wire logic [7:0] select_i,
  input wire logic [1:0] steer_i,
  output bpfs_route_t route_o
);

  // Two-bit field to function; upper bit clear means GPIO
  function automatic bpfs_fn_t two_bit_fn(input logic [1:0] f);
    if (!f[1]) begin
      return BPFS_FN_GPIO;
    end
    return f[0] ? BPFS_FN_BUS : BPFS_FN_DMA;
  endfunction

  // Pure decode, registered by the parent
  always_comb begin
    route_o.start_fn = two_bit_fn(busctl_i[BPFS_START_LSB +: 2]);
    route_o.inprog_fn = two_bit_fn(busctl_i[BPFS_INPROG_LSB +: 2]);
    route_o.strobe_bus = strobe_i[3:0];
    route_o.select_fn_on = select_i[7:1];
    // Steering only matters where the assign bit is set
    route_o.select_sdram[2] = select_i[2] & steer_i[0];
    route_o.select_sdram[3] = select_i[3] & steer_i[1];
  end

endmodule

//--- bpfs_top.sv
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module bpfs_top
  import bpfs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output bpfs_route_t route_o
);

  logic [15:0] busctl_reg;
  logic [7:0] strobe_reg;
  logic [7:0] select_reg;
  logic [1:0] steer_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [31:0] rd_word;
  logic rd_hit;
  bpfs_route_t route_next;

  // Merge new bytes under strobe, then keep writable bits only
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r & mask;
  endfunction

  // Address and data are caught in either order
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Ready drops once a channel is held so a second beat cannot slip in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held_reg && !(s_axi_awvalid_i && s_axi_awready_o)
                         && !s_axi_bvalid_o;
      s_axi_wready_o <= !w_held_reg && !(s_axi_wvalid_i && s_axi_wready_o)
                        && !s_axi_bvalid_o;
    end
  end

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

  // Register writes; reserved bits masked so they always read zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busctl_reg <= BPFS_BUSCTL_RST;
      strobe_reg <= BPFS_STROBE_RST;
      select_reg <= BPFS_SELECT_RST;
      steer_reg <= BPFS_STEER_RST;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        BPFS_BUSCTL_ADDR: begin
          busctl_reg <= 16'(merge({16'h0000, busctl_reg}, w_data_reg,
                            w_strb_reg, {16'h0000, BPFS_BUSCTL_MASK}));
        end
        BPFS_STROBE_ADDR: begin
          strobe_reg <= 8'(merge({24'h000000, strobe_reg}, w_data_reg,
                           w_strb_reg, {24'h000000, BPFS_STROBE_MASK}));
        end
        BPFS_SELECT_ADDR: begin
          select_reg <= 8'(merge({24'h000000, select_reg}, w_data_reg,
                           w_strb_reg, {24'h000000, BPFS_SELECT_MASK}));
        end
        BPFS_SDRAM_ADDR: begin
          if (w_strb_reg[0]) begin
            steer_reg <= w_data_reg[BPFS_STEER_LSB +: 2];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= BPFS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_addr_reg[1:0] == 2'h0) ? BPFS_RESP_OKAY
                                                   : BPFS_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read mux; every aligned word in the 16-byte space is mapped
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = (s_axi_araddr_i[1:0] == 2'h0);
    unique case (s_axi_araddr_i)
      BPFS_BUSCTL_ADDR: rd_word = {16'h0000, busctl_reg};
      BPFS_STROBE_ADDR: rd_word = {24'h000000, strobe_reg};
      BPFS_SELECT_ADDR: rd_word = {24'h000000, select_reg};
      BPFS_SDRAM_ADDR: rd_word = 32'(steer_reg) << BPFS_STEER_LSB;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read: one cycle address accept, data the next
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= BPFS_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o
                         && s_axi_arvalid_i;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rd_hit ? BPFS_RESP_OKAY : BPFS_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  bpfs_decode u_decode (
    .busctl_i(busctl_reg),
    .strobe_i(strobe_reg),
    .select_i(select_reg),
    .steer_i(steer_reg),
    .route_o(route_next)
  );

  // Routing is registered so pins never see decode glitches
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_o <= '0;
    end else begin
      route_o <= route_next;
    end
  end

  property p_start_route;
    @(posedge mclk_i) disable iff (!rst_n_i)
    busctl_reg[3:2] == 2'b10 |=> route_o.start_fn == BPFS_FN_DMA;
  endproperty
  a_start_route: assert property (p_start_route)
    else $error("start pin not on DMA acknowledge");

  property p_inprog_route;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !busctl_reg[1] |=> route_o.inprog_fn == BPFS_FN_GPIO;
  endproperty
  a_inprog_route: assert property (p_inprog_route)
    else $error("in-progress pin not on GPIO");

  property p_strobe_route;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ##1 route_o.strobe_bus == $past(strobe_reg[3:0]);
  endproperty
  a_strobe_route: assert property (p_strobe_route)
    else $error("strobe routing mismatch");

  property p_reserved_zero;
    @(posedge mclk_i) disable iff (!rst_n_i)
    strobe_reg[7:4] == 4'h0 && select_reg[0] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit held a one");

  property p_select_high;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $changed(select_reg[7:4]) |=> route_o.select_fn_on[7:4] ==
      $past(select_reg[7:4]);
  endproperty
  a_select_high: assert property (p_select_high)
    else $error("high chip selects not routed");

  property p_sdram_gated;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !select_reg[2] |=> !route_o.select_sdram[2] && !route_o.select_fn_on[2];
  endproperty
  a_sdram_gated: assert property (p_sdram_gated)
    else $error("steering acted on a GPIO pin");

  property p_steer;
    @(posedge mclk_i) disable iff (!rst_n_i)
    select_reg[3] && steer_reg == 2'b10 |=> route_o.select_sdram[3]
      && !route_o.select_sdram[2];
  endproperty
  a_steer: assert property (p_steer)
    else $error("steering code 10 misrouted");

  property p_select_one;
    @(posedge mclk_i) disable iff (!rst_n_i)
    select_reg[1] |=> route_o.select_fn_on[1];
  endproperty
  a_select_one: assert property (p_select_one)
    else $error("select pin one not on interface function");

  property p_start_gpio;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !busctl_reg[3] |=> route_o.start_fn == BPFS_FN_GPIO;
  endproperty
  a_start_gpio: assert property (p_start_gpio)
    else $error("start pin not on GPIO");

  property p_start_bus;
    @(posedge mclk_i) disable iff (!rst_n_i)
    busctl_reg[3:2] == 2'h3 |=> route_o.start_fn == BPFS_FN_BUS;
  endproperty
  a_start_bus: assert property (p_start_bus)
    else $error("start pin not on bus function");

  property p_inprog_dma;
    @(posedge mclk_i) disable iff (!rst_n_i)
    busctl_reg[1:0] == 2'h2 |=> route_o.inprog_fn == BPFS_FN_DMA;
  endproperty
  a_inprog_dma: assert property (p_inprog_dma)
    else $error("in-progress pin not on DMA request");

  property p_select_one_gpio;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !select_reg[1] |=> !route_o.select_fn_on[1];
  endproperty
  a_select_one_gpio: assert property (p_select_one_gpio)
    else $error("select pin one not on GPIO");

  property p_steer_pin_two;
    @(posedge mclk_i) disable iff (!rst_n_i)
    select_reg[2] && steer_reg[0] |=> route_o.select_sdram[2];
  endproperty
  a_steer_pin_two: assert property (p_steer_pin_two)
    else $error("pin two not on SDRAM select");

  // Write response must follow the internal write strobe
  property p_write_answer;
    @(posedge mclk_i) disable iff (!rst_n_i)
    do_write |=> s_axi_bvalid_o;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing");

  // Read data must follow an accepted read address
  property p_read_answer;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data missing");

endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import bpfs_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [1:0] r;
  bpfs_route_t route;
  int error_cnt = 0;
  int checked = 0;
  // Free-running 10 MHz clock
  always #50 mclk_i = ~mclk_i;
  bpfs_top uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .route_o(route)
  );
  // Single exit point for pass, fail and hang
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_fn(input string nm, input bpfs_fn_t e,
                        input bpfs_fn_t g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %s seen %s", nm, e.name(), g.name());
    end
  endtask
  // A stuck handshake must not hang the run
  task automatic tmo(input int n);
    if (n >= 50) begin
      error_cnt++;
      $display("[ERR] handshake expected answer seen none");
      print_verdict();
    end
  endtask
  // Write: AW and W offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    bit aw_on;
    bit w_on;
    n = 0;
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge mclk_i);
      n++;
      tmo(n);
      if (aw_on && awready === 1'b1) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) begin
      @(posedge mclk_i);
      n++;
      tmo(n);
    end
    bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  // Read: rready held until rvalid is sampled high
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1) begin
      @(posedge mclk_i);
      n++;
      tmo(n);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    // Let an edge pass so a following read never re-drives rready now
    @(posedge mclk_i);
  endtask
  // Write, read back, compare word and response
  task automatic wrd(input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    wr(a, d, BPFS_RESP_OKAY);
    rd(a, v, r);
    cmp("readback", e, v);
    cmp("rresp", 32'h0, {30'h0, r});
  endtask
  function automatic bpfs_fn_t fn_of(input logic [1:0] c);
    return c[1] ? (c[0] ? BPFS_FN_BUS : BPFS_FN_DMA) : BPFS_FN_GPIO;
  endfunction
  task automatic t_reset();
    cmp("route", 32'h0, 32'(route));
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), v, r);
      cmp("reset reg", 32'h0, v);
    end
    $display("test reset done");
  endtask
  // Every code of both fields, unwritable bits set
  task automatic t_busctl();
    for (int c = 0; c < 4; c++) begin
      wrd(BPFS_BUSCTL_ADDR, 32'h5D50 | (c << 2) | (3 - c), (c << 2) | (3 - c));
      cmp_fn("start", fn_of(2'(c)), route.start_fn);
      cmp_fn("inprog", fn_of(2'(3 - c)), route.inprog_fn);
    end
    $display("test busctl done");
  endtask
  task automatic t_strobe();
    // Reserved upper bits are always written as zero
    wrd(BPFS_STROBE_ADDR, 32'h05, 32'h05);
    cmp("strobe", 32'h5, 32'(route.strobe_bus));
    wrd(BPFS_STROBE_ADDR, 32'h0A, 32'h0A);
    cmp("strobe", 32'hA, 32'(route.strobe_bus));
    $display("test strobe done");
  endtask
  task automatic t_select();
    wrd(BPFS_SELECT_ADDR, 32'hAA, 32'hAA);
    cmp("select", 32'h55, 32'(route.select_fn_on));
    wrd(BPFS_SELECT_ADDR, 32'h54, 32'h54);
    cmp("select", 32'h2A, 32'(route.select_fn_on));
    $display("test select done");
  endtask
  // Steering is gated per pin by the select bits
  task automatic t_steer();
    logic [1:0] e;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        wrd(BPFS_SELECT_ADDR, p << 2, p << 2);
        wrd(BPFS_SDRAM_ADDR, s << 6, s << 6);
        e = 2'(p & s);
        cmp("sdram", 32'(e), 32'(route.select_sdram));
      end
    end
    $display("test steer done");
  endtask
  // Unaligned write is refused and leaves the register alone
  task automatic t_unaligned();
    wrd(BPFS_BUSCTL_ADDR, 32'h3, 32'h3);
    wr(4'h2, 32'h0, BPFS_RESP_SLVERR);
    rd(BPFS_BUSCTL_ADDR, v, r);
    cmp("busctl", 32'h3, v);
    // Unaligned read is refused with an error response
    rd(4'h6, v, r);
    cmp("rresp", {30'h0, BPFS_RESP_SLVERR}, {30'h0, r});
    $display("test unaligned done");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_busctl();
    t_strobe();
    t_select();
    t_steer();
    t_unaligned();
    print_verdict();
  end
endmodule
